// >>> hdl/usc_pkg.sv
// Constants, field layout and carriers of the USB switch / charger register bank
// Summary of operation
// R01: Switching delay code, 10 ms plus 20 ms steps
// R02: Long key code, 300 ms plus 100 ms steps
// R03: Accessory type one flags, read-only, reset zero
// R04: Accessory type two flags, read-only, reset zero
// R05: Key state low reports keys seven to send
// R06: Key state high reports keys fourteen to eight
// R07: Minus line code selects open, hs, tx
// R08: Plus line code selects open, hs, rx
// R09: Manual routing applies only in manual mode
// R10: Boot level driven; factory pull open-drain
// R11: Reset bit resets device, self-clears after
// R12: Force-off beats detection and enable override
// R13: Recharge threshold field, reset zero
// R14: Override off: charge only with charger detected
// R15: Fast charge allowed only when bit set
// R16: Host clears fast allow only in pre-charge; code accepts the write in any charge phase
// R17: Fast timer limit five/six/seven hours or off
// R18: Timer over limit sets expired flag
// R19: Expiry disables charging until reattach or toggle
// R20: Switching delay only while wait bit set; code holds the automatic switch pending while the bit is clear
// R21: Unused bits read zero, writes ignored
// R22: Invalid field codes keep previous setting
package usc_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_SEC;
  localparam int unsigned HOUR_MS       = 3_600_000;
  localparam int unsigned SRST_CYCLES   = 4;

  localparam logic [7:0] OFS_TIMING     = 8'h09;
  localparam logic [7:0] OFS_ACC_ONE    = 8'h0A;
  localparam logic [7:0] OFS_ACC_TWO    = 8'h0B;
  localparam logic [7:0] OFS_KEY_LOW    = 8'h0C;
  localparam logic [7:0] OFS_KEY_HIGH   = 8'h0D;
  localparam logic [7:0] OFS_ROUTING    = 8'h13;
  localparam logic [7:0] OFS_FACTORY    = 8'h14;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h1B;
  localparam logic [7:0] OFS_CHARGE_ONE = 8'h20;

  localparam int unsigned POS_SW_WAIT   = 4;
  localparam int unsigned POS_LONG_KEY  = 0;
  localparam int unsigned POS_MINUS     = 5;
  localparam int unsigned POS_PLUS      = 2;
  localparam int unsigned POS_BOOT      = 3;
  localparam int unsigned POS_JIG       = 2;
  localparam int unsigned POS_SRST      = 0;
  localparam int unsigned POS_FORCE_OFF = 7;
  localparam int unsigned POS_THRESH    = 5;
  localparam int unsigned POS_ENOV      = 4;
  localparam int unsigned POS_FAST      = 3;
  localparam int unsigned POS_TLIM      = 0;

  localparam logic [3:0] RST_SW_WAIT    = 4'h0;
  localparam logic [3:0] RST_LONG_KEY   = 4'h0;
  localparam logic [2:0] RST_ROUTE      = 3'h0;
  localparam logic       RST_BOOT       = 1'b0;
  localparam logic       RST_JIG        = 1'b0;
  localparam logic       RST_FORCE_OFF  = 1'b0;
  localparam logic [1:0] RST_THRESH     = 2'h0;
  localparam logic       RST_ENOV       = 1'b1;
  localparam logic       RST_FAST       = 1'b1;
  localparam logic [1:0] RST_TLIM       = 2'h0;

  localparam logic [3:0] MAX_SW_WAIT    = 4'hA;
  localparam logic [3:0] MAX_LONG_KEY   = 4'hC;
  localparam logic [2:0] MAX_ROUTE      = 3'h3;
  localparam logic [2:0] ROUTE_HS       = 3'h1;
  localparam logic [2:0] ROUTE_UART     = 3'h3;
  localparam logic [1:0] TLIM_OFF       = 2'h3;

  localparam int unsigned SW_WAIT_BASE_MS  = 10;
  localparam int unsigned SW_WAIT_STEP_MS  = 20;
  localparam int unsigned LONG_KEY_BASE_MS = 300;
  localparam int unsigned LONG_KEY_STEP_MS = 100;
  localparam int unsigned FAST_BASE_HOURS  = 5;

  typedef struct packed {
    logic minus_hs;
    logic minus_uart_tx;
    logic plus_hs;
    logic plus_uart_rx;
  } usc_route_s;

  typedef struct packed {
    logic [7:0] acc_one;
    logic [7:0] acc_two;
    logic [7:0] key_low;
    logic [6:0] key_high;
  } usc_detect_s;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WDATA, I2C_ACK, I2C_RDATA, I2C_RACK, I2C_RLOAD
  } usc_i2c_e;
endpackage

// >>> hdl/usc_regs.sv
// I2C-reached register bank with routing, factory outputs and charger control
module usc_regs
  import usc_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR    = 7'h25,
  parameter int unsigned MS_CYC      = MS_CYCLES,
  parameter int unsigned HOUR_LEN_MS = HOUR_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire usc_detect_s detect,
  input  wire logic        detect_done,
  input  wire usc_route_s  auto_route,
  input  wire logic        hand_routing_select,
  input  wire logic        wait_select,
  input  wire logic        charger_detected,
  input  wire logic        charger_attached,
  input  wire logic        in_fast_charge,
  output usc_route_s       switch_route,
  output logic [10:0]      long_key_ms,
  output logic             boot_level_out,
  output logic             factory_pull_low_o,
  output logic             factory_pull_low_oe_n,
  output logic             charge_enable,
  output logic             fast_charge_allow,
  output logic [1:0]       recharge_threshold,
  output logic             fast_timer_expired,
  output logic             soft_reset_busy
);
  // I2C pin front end
  logic [2:0] scl_s_r, sda_s_r;
  logic       scl_f_r, sda_f_r, scl_p_r, sda_p_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise  = scl_f_r & ~scl_p_r;
  assign scl_fall  = ~scl_f_r & scl_p_r;
  assign i2c_start = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign i2c_stop  = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // Register state
  logic [3:0] sw_wait_r, long_key_r;
  logic [2:0] minus_r, plus_r;
  logic       boot_r, jig_r;
  logic       force_off_r, enov_r, fast_r;
  logic [1:0] thresh_r, tlim_r;
  logic [2:0] srst_cnt_r;
  logic       srst_act;
  usc_detect_s det_r;
  assign srst_act = (srst_cnt_r != 3'h0);

  // Read mux; unused bits read zero [R21]
  logic [7:0] ptr_r, rd_byte;
  always_comb begin
    case (ptr_r)
      OFS_TIMING:     rd_byte = {sw_wait_r, long_key_r};
      OFS_ACC_ONE:    rd_byte = det_r.acc_one;             // [R03]
      OFS_ACC_TWO:    rd_byte = det_r.acc_two;             // [R04]
      OFS_KEY_LOW:    rd_byte = det_r.key_low;             // [R05]
      OFS_KEY_HIGH:   rd_byte = {1'b0, det_r.key_high};    // [R06]
      OFS_ROUTING:    rd_byte = {minus_r, plus_r, 2'h0};
      OFS_FACTORY:    rd_byte = {4'h0, boot_r, jig_r, 2'h0};
      OFS_SOFT_RESET: rd_byte = {7'h00, srst_act};
      OFS_CHARGE_ONE: rd_byte = {force_off_r, thresh_r, enov_r, fast_r, 1'b0, tlim_r};
      default:        rd_byte = 8'h00;
    endcase
  end

  // I2C slave engine; survives soft reset so the ACK of the reset write completes
  usc_i2c_e   st_r, after_ack_r;
  logic [7:0] sh_r;
  logic [2:0] bitc_r;
  logic       ack_on_r, sda_low_r, wr_stb_r;
  logic [7:0] wr_addr_r, wr_data_r;
  logic [7:0] byte_in;
  assign byte_in = {sh_r[6:0], sda_f_r};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= I2C_IDLE;
      after_ack_r <= I2C_IDLE;
      sh_r        <= 8'h00;
      bitc_r      <= 3'h0;
      ack_on_r    <= 1'b0;
      sda_low_r   <= 1'b0;
      ptr_r       <= 8'h00;
      wr_stb_r    <= 1'b0;
      wr_addr_r   <= 8'h00;
      wr_data_r   <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (i2c_start) begin
        st_r      <= I2C_ADDR;
        bitc_r    <= 3'h0;
        sda_low_r <= 1'b0;
        ack_on_r  <= 1'b0;
      end else if (i2c_stop) begin
        st_r      <= I2C_IDLE;
        sda_low_r <= 1'b0;
      end else if (scl_rise) begin
        case (st_r)
          I2C_ADDR, I2C_PTR, I2C_WDATA: begin
            sh_r   <= byte_in;
            bitc_r <= bitc_r + 3'h1;
            if (bitc_r == 3'h7) begin
              st_r <= I2C_ACK;
              if (st_r == I2C_ADDR) begin
                if (byte_in[7:1] != DEV_ADDR) st_r <= I2C_IDLE;
                after_ack_r <= byte_in[0] ? I2C_RDATA : I2C_PTR;
              end else if (st_r == I2C_PTR) begin
                ptr_r       <= byte_in;
                after_ack_r <= I2C_WDATA;
              end else begin
                wr_stb_r    <= 1'b1;
                wr_addr_r   <= ptr_r;
                wr_data_r   <= byte_in;
                ptr_r       <= ptr_r + 8'h01;
                after_ack_r <= I2C_WDATA;
              end
            end
          end
          I2C_RDATA: begin
            bitc_r <= bitc_r + 3'h1;
            if (bitc_r == 3'h7) st_r <= I2C_RACK;
          end
          I2C_RACK: begin
            if (sda_f_r) begin
              st_r <= I2C_IDLE;
            end else begin
              st_r  <= I2C_RLOAD;
              sh_r  <= rd_byte;
              ptr_r <= ptr_r + 8'h01;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_r)
          I2C_ACK: begin
            if (!ack_on_r) begin
              ack_on_r  <= 1'b1;
              sda_low_r <= 1'b1;
            end else begin
              ack_on_r  <= 1'b0;
              bitc_r    <= 3'h0;
              st_r      <= after_ack_r;
              sda_low_r <= 1'b0;
              if (after_ack_r == I2C_RDATA) begin
                sh_r      <= rd_byte;
                sda_low_r <= ~rd_byte[7];
                ptr_r     <= ptr_r + 8'h01;
              end
            end
          end
          I2C_RDATA: sda_low_r <= ~sh_r[3'h7 - bitc_r];
          I2C_RLOAD: begin
            st_r      <= I2C_RDATA;
            bitc_r    <= 3'h0;
            sda_low_r <= ~sh_r[7];
          end
          default: sda_low_r <= 1'b0;
        endcase
      end
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~sda_low_r;

  logic wr_timing, wr_route, wr_fact, wr_chg;
  assign wr_timing = wr_stb_r & (wr_addr_r == OFS_TIMING);
  assign wr_route  = wr_stb_r & (wr_addr_r == OFS_ROUTING);
  assign wr_fact   = wr_stb_r & (wr_addr_r == OFS_FACTORY);
  assign wr_chg    = wr_stb_r & (wr_addr_r == OFS_CHARGE_ONE);

  // Soft reset: a short internal pulse, bit reads back 1 while it lasts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      srst_cnt_r <= 3'h0;
    end else if (srst_act) begin
      srst_cnt_r <= srst_cnt_r - 3'h1;                                       // [R11]
    end else if (wr_stb_r && wr_addr_r == OFS_SOFT_RESET && wr_data_r[POS_SRST]) begin
      srst_cnt_r <= 3'(SRST_CYCLES);                                         // [R11]
    end
  end

  // Host-written fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_wait_r   <= RST_SW_WAIT;
      long_key_r  <= RST_LONG_KEY;
      minus_r     <= RST_ROUTE;
      plus_r      <= RST_ROUTE;
      boot_r      <= RST_BOOT;
      jig_r       <= RST_JIG;
      force_off_r <= RST_FORCE_OFF;
      thresh_r    <= RST_THRESH;
      enov_r      <= RST_ENOV;
      fast_r      <= RST_FAST;
      tlim_r      <= RST_TLIM;
    end else if (srst_act) begin
      sw_wait_r   <= RST_SW_WAIT;                                            // [R11]
      long_key_r  <= RST_LONG_KEY;
      minus_r     <= RST_ROUTE;
      plus_r      <= RST_ROUTE;
      boot_r      <= RST_BOOT;
      jig_r       <= RST_JIG;
      force_off_r <= RST_FORCE_OFF;
      thresh_r    <= RST_THRESH;
      enov_r      <= RST_ENOV;
      fast_r      <= RST_FAST;
      tlim_r      <= RST_TLIM;
    end else begin
      if (wr_timing && wr_data_r[POS_SW_WAIT +: 4] <= MAX_SW_WAIT)
        sw_wait_r <= wr_data_r[POS_SW_WAIT +: 4];                            // [R01] [R22]
      if (wr_timing && wr_data_r[POS_LONG_KEY +: 4] <= MAX_LONG_KEY)
        long_key_r <= wr_data_r[POS_LONG_KEY +: 4];                          // [R02] [R22]
      if (wr_route && wr_data_r[POS_MINUS +: 3] <= MAX_ROUTE)
        minus_r <= wr_data_r[POS_MINUS +: 3];                                // [R07] [R22]
      if (wr_route && wr_data_r[POS_PLUS +: 3] <= MAX_ROUTE)
        plus_r <= wr_data_r[POS_PLUS +: 3];                                  // [R08] [R22]
      if (wr_fact) begin
        boot_r <= wr_data_r[POS_BOOT];                                       // [R10]
        jig_r  <= wr_data_r[POS_JIG];                                        // [R10]
      end
      if (wr_chg) begin
        force_off_r <= wr_data_r[POS_FORCE_OFF];                             // [R12]
        thresh_r    <= wr_data_r[POS_THRESH +: 2];                           // [R13]
        enov_r      <= wr_data_r[POS_ENOV];                                  // [R14]
        fast_r      <= wr_data_r[POS_FAST];                                  // [R15] [R16]
        tlim_r      <= wr_data_r[POS_TLIM +: 2];                             // [R17]
      end
    end
  end

  // Detection snapshot for the read-only registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) det_r <= '0;
    else if (srst_act) det_r <= '0;
    else det_r <= detect;
  end

  // Millisecond tick shared by switching delay and fast-charge timer
  logic [$clog2(MS_CYC)-1:0] pre_r;
  logic                      tick_ms;
  assign tick_ms = (pre_r == ($clog2(MS_CYC))'(MS_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pre_r <= '0;
    else if (tick_ms) pre_r <= '0;
    else pre_r <= pre_r + 1'b1;
  end

  // Switching delay between detection done and automatic switching
  logic       pend_r;
  logic [7:0] dly_ms_r, sw_wait_ms;
  usc_route_s auto_hold_r, auto_appl_r, manual_route;
  assign sw_wait_ms = 8'(SW_WAIT_BASE_MS) + 8'(SW_WAIT_STEP_MS) * {4'h0, sw_wait_r};  // [R01]
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r      <= 1'b0;
      dly_ms_r    <= 8'h00;
      auto_hold_r <= '0;
      auto_appl_r <= '0;
    end else if (srst_act) begin
      pend_r      <= 1'b0;
      dly_ms_r    <= 8'h00;
      auto_hold_r <= '0;
      auto_appl_r <= '0;
    end else if (detect_done) begin
      pend_r      <= 1'b1;
      dly_ms_r    <= 8'h00;
      auto_hold_r <= auto_route;
    end else if (pend_r && wait_select) begin                                // [R20]
      if (dly_ms_r >= sw_wait_ms) begin
        pend_r      <= 1'b0;
        auto_appl_r <= auto_hold_r;
      end else if (tick_ms) begin
        dly_ms_r <= dly_ms_r + 8'h01;
      end
    end
  end

  always_comb begin
    manual_route.minus_hs      = (minus_r == ROUTE_HS);                      // [R07]
    manual_route.minus_uart_tx = (minus_r == ROUTE_UART);                    // [R07]
    manual_route.plus_hs       = (plus_r == ROUTE_HS);                       // [R08]
    manual_route.plus_uart_rx  = (plus_r == ROUTE_UART);                     // [R08]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) switch_route <= '0;
    else switch_route <= hand_routing_select ? auto_appl_r : manual_route;   // [R09]
  end

  // Fast-charge timer; limits in ms fit 25 bits
  logic [24:0] fc_ms_r, fc_lim_ms;
  logic        expired_r, attach_p_r, enov_p_r, exp_set, exp_clr;
  assign fc_lim_ms = 25'((FAST_BASE_HOURS + 32'(tlim_r)) * HOUR_LEN_MS);     // [R17]
  assign exp_set   = in_fast_charge && (tlim_r != TLIM_OFF) && (fc_ms_r >= fc_lim_ms);  // [R18]
  assign exp_clr   = (charger_attached & ~attach_p_r) | (enov_r ^ enov_p_r);  // [R19]
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fc_ms_r    <= '0;
      expired_r  <= 1'b0;
      attach_p_r <= 1'b0;
      enov_p_r   <= RST_ENOV;
    end else begin
      attach_p_r <= charger_attached;
      enov_p_r   <= enov_r;
      if (srst_act || !in_fast_charge) fc_ms_r <= '0;
      else if (tick_ms && !exp_set) fc_ms_r <= fc_ms_r + 25'h1;
      // Set wins over a clear arriving in the same cycle
      if (exp_set) expired_r <= 1'b1;                                        // [R18]
      else if (srst_act || exp_clr) expired_r <= 1'b0;                       // [R19]
    end
  end

  // Outputs from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      charge_enable         <= 1'b0;
      fast_charge_allow     <= RST_FAST;
      recharge_threshold    <= RST_THRESH;
      fast_timer_expired    <= 1'b0;
      long_key_ms           <= 11'h000;
      boot_level_out        <= RST_BOOT;
      factory_pull_low_oe_n <= 1'b1;
      soft_reset_busy       <= 1'b0;
    end else begin
      charge_enable         <= ~force_off_r & ~expired_r & (enov_r | charger_detected);  // [R12] [R14] [R19]
      fast_charge_allow     <= fast_r;                                       // [R15]
      recharge_threshold    <= thresh_r;                                     // [R13]
      fast_timer_expired    <= expired_r;                                    // [R18]
      long_key_ms           <= 11'(LONG_KEY_BASE_MS) + 11'(LONG_KEY_STEP_MS) * {7'h00, long_key_r};  // [R02]
      boot_level_out        <= boot_r;                                       // [R10]
      factory_pull_low_oe_n <= ~jig_r;                                       // [R10]
      soft_reset_busy       <= srst_act;
    end
  end
  assign factory_pull_low_o = 1'b0;
endmodule

// >>> test/test_usc_regs.sv
// Self-checking bench for the register bank via the host model
module test_usc_regs
  import usc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MSC = 10;
  localparam logic [6:0]  DEV = 7'h25;
  logic        clk_sys, rst_n, scl, sda, sda_low, sda_o, sda_oe_n, ack;
  logic        detect_done, hand_routing_select, wait_select, charger_detected, charger_attached, in_fast_charge;
  logic        boot_level_out, factory_pull_low_o, factory_pull_low_oe_n, charge_enable;
  logic        fast_charge_allow, fast_timer_expired, soft_reset_busy;
  logic [1:0]  recharge_threshold;
  logic [10:0] long_key_ms;
  logic [7:0]  rd, w;
  logic [3:0]  sw, lk, m, p;
  usc_detect_s detect;
  usc_route_s  auto_route, switch_route;
  int          miscompares, n_checks;
  localparam logic [7:0] RA [10] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h14, 8'h1B, 8'h20, 8'h30};

  assign sda = (sda_oe_n | sda_o) & ~sda_low;
  always #10 clk_sys = ~clk_sys;

  usc_i2c_host host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
  usc_regs #(.DEV_ADDR(DEV), .MS_CYC(MSC), .HOUR_LEN_MS(3)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .detect(detect), .detect_done(detect_done), .auto_route(auto_route),
    .hand_routing_select(hand_routing_select), .wait_select(wait_select), .charger_detected(charger_detected),
    .charger_attached(charger_attached), .in_fast_charge(in_fast_charge), .switch_route(switch_route),
    .long_key_ms(long_key_ms), .boot_level_out(boot_level_out), .factory_pull_low_o(factory_pull_low_o),
    .factory_pull_low_oe_n(factory_pull_low_oe_n), .charge_enable(charge_enable),
    .fast_charge_allow(fast_charge_allow), .recharge_threshold(recharge_threshold),
    .fast_timer_expired(fast_timer_expired), .soft_reset_busy(soft_reset_busy));

  function automatic logic [3:0] keep(input logic [3:0] o, n, mx);
    return (n <= mx) ? n : o;
  endfunction
  function automatic logic [3:0] rte(input logic [3:0] a, b);
    return {a == 4'h1, a == 4'h3, b == 4'h1, b == 4'h3};
  endfunction
  task automatic chk(input string n, input logic [10:0] e, s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.write_reg(DEV, a, d, ack);
    chk("ack", 11'h1, 11'(ack));
  endtask
  task automatic rdc(input logic [7:0] a, e);
    host.read_reg(DEV, a, rd);
    chk($sformatf("reg %h", a), 11'(e), 11'(rd));
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("n_checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #2_000_000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {clk_sys, rst_n, detect, detect_done, auto_route, hand_routing_select, wait_select} = '0;
    {charger_detected, charger_attached, in_fast_charge, miscompares, n_checks} = '0;
    void'($urandom(67867));
    ticks(3);
    rst_n = 1'b1;
    ticks(6);
    chk("long key", 11'd300, long_key_ms);
    foreach (RA[i]) rdc(RA[i], (RA[i] == 8'h20) ? 8'h18 : 8'h00);
    {sw, lk} = 8'h00;
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'hAC : (i == 1) ? 8'hBD : 8'($urandom);
      wr(8'h09, w);
      sw = keep(sw, w[7:4], 4'hA);
      lk = keep(lk, w[3:0], 4'hC);
      rdc(8'h09, {sw, lk});
      chk("long key", 11'(300 + 100 * lk), long_key_ms);
    end
    detect = 31'($urandom);
    wr(8'h0A, 8'hFF);
    rdc(8'h0A, detect.acc_one);
    rdc(8'h0B, detect.acc_two);
    rdc(8'h0C, detect.key_low);
    rdc(8'h0D, {1'b0, detect.key_high});
    {m, p} = 8'h00;
    for (int i = 0; i < 16; i++) begin
      w = {i[2:0], 3'(i * 3), 2'($urandom)};
      wr(8'h13, w);
      m = keep(m, {1'b0, w[7:5]}, 4'h3);
      p = keep(p, {1'b0, w[4:2]}, 4'h3);
      rdc(8'h13, {m[2:0], p[2:0], 2'b00});
      chk("route", 11'(rte(m, p)), 11'(switch_route));
    end
    for (int i = 0; i < 4; i++) begin
      w = {4'($urandom), i[1:0], 2'($urandom)};
      wr(8'h14, w);
      rdc(8'h14, w & 8'h0C);
      chk("boot", 11'(w[3]), 11'(boot_level_out));
      chk("jig", 11'(!w[2]), 11'(factory_pull_low_oe_n));
    end
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 8'h90 : (i == 1) ? 8'h00 : 8'($urandom);
      charger_detected = (i > 1) & 1'($urandom);
      wr(8'h20, w);
      rdc(8'h20, w & 8'hFB);
      chk("thresh", 11'(w[6:5]), 11'(recharge_threshold));
      chk("fast", 11'(w[3]), 11'(fast_charge_allow));
      chk("chg", 11'(!w[7] & (w[4] | charger_detected)), 11'(charge_enable));
    end
    charger_detected = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, 8'h18 | 8'(c));
      in_fast_charge = 1'b1;
      ticks((13 + 3 * c) * MSC);
      chk("early", 11'h0, 11'(fast_timer_expired));
      ticks(4 * MSC);
      chk("expired", 11'(c != 3), 11'(fast_timer_expired));
      chk("chg", 11'(c == 3), 11'(charge_enable));
      in_fast_charge = 1'b0;
      if (c[0])
        wr(8'h20, 8'h08 | 8'(c));
      charger_attached = !c[0];
      ticks(5);
      charger_attached = 1'b0;
      chk("cleared", 11'h0, 11'(fast_timer_expired));
      chk("chg", 11'(!c[0]), 11'(charge_enable));
    end
    wr(8'h09, 8'h5A);
    wr(8'h1B, 8'h01);
    rdc(8'h1B, 8'h00);
    rdc(8'h09, 8'h00);
    rdc(8'h20, 8'h18);
    hand_routing_select = 1'b1;
    auto_route = 4'hA;
    detect_done = 1'b1;
    ticks(1);
    detect_done = 1'b0;
    ticks(300);
    chk("held", 11'h0, 11'(switch_route));
    wait_select = 1'b1;
    ticks(8 * MSC);
    chk("early", 11'h0, 11'(switch_route));
    ticks(4 * MSC);
    chk("switched", 11'hA, 11'(switch_route));
    hand_routing_select = 1'b0;
    ticks(3);
    chk("manual", 11'h0, 11'(switch_route));
    host.write_reg(7'h26, 8'h14, 8'h0C, ack);
    chk("nack", 11'h0, 11'(ack));
    rdc(8'h14, 8'h00);
    wr(8'h30, 8'hFF);
    rdc(8'h30, 8'h00);
    end_of_test();
  end
endmodule

// >>> test/usc_i2c_host.sv
// Host processor model acting as two-wire bus master
module usc_i2c_host (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit; well above the device's input filter
  task automatic q();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic start();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // Data changes only mid-low phase; last slot is the acknowledge
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      q();
      sda_low = ~d[i];
      q();
      scl = 1'b1;
      q();
      q();
      r[i] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, d, output logic ack);
    logic [8:0] r0, r1, r2;
    start();
    xbyte({dev, 2'b01}, r0);
    xbyte({p, 1'b1}, r1);
    xbyte({d, 1'b1}, r2);
    stop();
    ack = !(r0[0] | r1[0] | r2[0]);
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r;
    start();
    xbyte({dev, 2'b01}, r);
    xbyte({p, 1'b1}, r);
    start();
    xbyte({dev, 2'b11}, r);
    xbyte(9'h1FF, r);
    stop();
    d = r[8:1];
  endtask
endmodule

// >>> test/usc_regs_checker.sv
// Port-level assertions on the register bank, bound into every instance
module usc_regs_checker
  import usc_pkg::*;
#(
  parameter int unsigned MS_CYC      = MS_CYCLES,
  parameter int unsigned HOUR_LEN_MS = HOUR_MS
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        sda_o,
  input wire logic        hand_routing_select,
  input wire logic        charger_attached,
  input wire logic        in_fast_charge,
  input wire usc_route_s  switch_route,
  input wire logic [10:0] long_key_ms,
  input wire logic        boot_level_out,
  input wire logic        factory_pull_low_o,
  input wire logic        factory_pull_low_oe_n,
  input wire logic        charge_enable,
  input wire logic        fast_charge_allow,
  input wire logic [1:0]  recharge_threshold,
  input wire logic        fast_timer_expired,
  input wire logic        soft_reset_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Cycles spent in fast charge without a break
  int unsigned fc_cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      fc_cnt <= 0;
    else
      fc_cnt <= in_fast_charge ? fc_cnt + 1 : 0;
  end

  long_key_a: assert property (
    $past(rst_n) |-> long_key_ms >= 11'h12C && long_key_ms <= 11'h5DC && long_key_ms % 11'h064 == 11'h000)
    else $error("long key duration off its scale");
  route_legal_a: assert property (
    !(switch_route.minus_hs && switch_route.minus_uart_tx) && !(switch_route.plus_hs && switch_route.plus_uart_rx))
    else $error("data line on two paths at once");
  open_drain_a: assert property (
    sda_o == 1'b0 && factory_pull_low_o == 1'b0)
    else $error("open drain pin driven high");
  srst_len_a: assert property (
    $rose(soft_reset_busy) |-> soft_reset_busy [*3] ##[1:3] !soft_reset_busy)
    else $error("soft reset length wrong");
  srst_clear_a: assert property (
    $fell(soft_reset_busy) |-> ##[0:2] (long_key_ms == 11'd300 && fast_charge_allow && recharge_threshold == 2'h0
      && !boot_level_out && factory_pull_low_oe_n && !fast_timer_expired))
    else $error("soft reset left state behind");
  expiry_min_a: assert property (
    $rose(fast_timer_expired) |-> fc_cnt >= (5 * HOUR_LEN_MS - 2) * MS_CYC)
    else $error("fast timer expired too soon");
  expired_off_a: assert property (
    fast_timer_expired [*2] |-> !charge_enable)
    else $error("charging while timer expired");
  attach_clear_a: assert property (
    $rose(charger_attached) && !in_fast_charge |-> ##[1:4] !fast_timer_expired)
    else $error("reattach did not clear expiry");

  cover property ($rose(fast_timer_expired));
  cover property ($rose(soft_reset_busy));
  cover property (hand_routing_select && $changed(switch_route));
endmodule

bind usc_regs usc_regs_checker #(.MS_CYC(MS_CYC), .HOUR_LEN_MS(HOUR_LEN_MS)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .sda_o(sda_o), .hand_routing_select(hand_routing_select),
  .charger_attached(charger_attached), .in_fast_charge(in_fast_charge), .switch_route(switch_route),
  .long_key_ms(long_key_ms), .boot_level_out(boot_level_out), .factory_pull_low_o(factory_pull_low_o),
  .factory_pull_low_oe_n(factory_pull_low_oe_n), .charge_enable(charge_enable),
  .fast_charge_allow(fast_charge_allow), .recharge_threshold(recharge_threshold),
  .fast_timer_expired(fast_timer_expired), .soft_reset_busy(soft_reset_busy));
